// ### hw/mcu_fe_pkg.sv
// shared constants, types and carriers of the mcu bus front end
package mcu_fe_pkg;

	// ----------------------------------------
	// widths and pin bundle layout
	// ----------------------------------------
	localparam int ADDR_W    = 20;
	localparam int DATA_W    = 8;
	localparam int LOGIC_A_W = 16;
	localparam int PIN_W     = 28;
	localparam int LO_LSB    = 0;
	localparam int HI_LSB    = 8;
	localparam int SD_LSB    = 16;
	localparam int CTL_LSB   = 24;
	localparam int STRB_BIT  = 27;
	localparam int BURST_LSB = 4;

	// ----------------------------------------
	// reset and drive-enable values
	// ----------------------------------------
	localparam logic [DATA_W-1:0] OE_RST    = 8'h00;
	localparam logic [DATA_W-1:0] OE_ON     = 8'hFF;
	localparam logic              ABORT_RST = 1'b1;
	localparam logic              SYNC_RST  = 1'b1;

	// ----------------------------------------
	// modes, states and carriers
	// ----------------------------------------
	typedef enum logic [1:0] {
		STYLE_MUX    = 2'h0,
		STYLE_NONMUX = 2'h1,
		STYLE_PAGE   = 2'h2,
		STYLE_BURST  = 2'h3
	} bus_style_e;

	typedef enum logic [1:0] {
		C1_READ_N    = 2'h0,
		C1_ECLK      = 2'h1,
		C1_DSTROBE_N = 2'h2,
		C1_FETCH_N   = 2'h3
	} ctl1_mode_e;

	typedef enum logic [1:0] {
		CYC_IDLE = 2'h0,
		CYC_ADDR = 2'h1,
		CYC_HOLD = 2'h2
	} cyc_e;

	typedef struct packed {
		bus_style_e style;
		logic       strobe_alt;
		logic       ctl0_rw;
		ctl1_mode_e ctl1;
		logic       ctl2_fetch;
	} bus_cfg_s;

	typedef struct packed {
		logic read;
		logic write;
		logic prog_fetch;
		logic generic_in;
	} bus_ctrl_s;

endpackage

// ### hw/pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,   // core clock
	input  wire logic             rst_n, // async reset, low
	input  wire logic [WIDTH-1:0] din,   // raw pin levels
	output logic      [WIDTH-1:0] dout   // filtered levels
);

	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;

	// ----------------------------------------
	// per-bit chain, change taken when 2 and 3 agree
	// ----------------------------------------
	for (genvar i = 0; i < WIDTH; i++)
	begin : g_bit
		always_ff @(posedge clk or negedge rst_n)
		begin
			if (!rst_n)
			begin
				s1_q[i] <= mcu_fe_pkg::SYNC_RST;
				s2_q[i] <= mcu_fe_pkg::SYNC_RST;
				s3_q[i] <= mcu_fe_pkg::SYNC_RST;
				dout[i] <= mcu_fe_pkg::SYNC_RST;
			end
			else
			begin
				s1_q[i] <= din[i];
				s2_q[i] <= s1_q[i];
				s3_q[i] <= s2_q[i];
				if (s2_q[i] == s3_q[i])
					dout[i] <= s3_q[i];
			end
		end
	end

endmodule

// ### hw/ctl_decode.sv
// decode of the three bus control inputs
`timescale 1ns/1ps
module ctl_decode (
	input  wire logic                 c0,   // control_in_zero, synced
	input  wire logic                 c1,   // control_in_one, synced
	input  wire logic                 c2,   // control_in_two, synced
	input  wire mcu_fe_pkg::bus_cfg_s cfg,  // bus style
	output mcu_fe_pkg::bus_ctrl_s     ctrl  // decoded strobes
);

	logic strb1;
	logic fetch2;

	always_comb
	begin
		// e clock is active high, the other styles low
		strb1 = (cfg.ctl1 == mcu_fe_pkg::C1_ECLK) ? c1 : ~c1;
		fetch2 = cfg.ctl2_fetch & ~c2;
		ctrl = '0;
		if (cfg.ctl0_rw)
		begin
			// line is direction only, strobe qualifies
			ctrl.read  = (strb1 & c0) | fetch2;
			ctrl.write = strb1 & ~c0;
		end
		else
		begin
			ctrl.read  = strb1 | fetch2;
			ctrl.write = ~c0;
		end
		ctrl.prog_fetch = fetch2 | ((cfg.ctl1 == mcu_fe_pkg::C1_FETCH_N) & ~c1);
		ctrl.generic_in = cfg.ctl2_fetch ? 1'b0 : c2;
	end

endmodule

// ### hw/mcu_bus_front_end.sv
// front end facing an 8-bit mcu parallel address/data bus
//
// How it works
// - strobe latches both ports, held through cycle
// - alternate strobe latches on rising edge
// - drive data only on read with unit selected
// - port addresses forwarded to logic arrays
// - multiplexed: low port address/data, high upper
// - non-multiplexed: both ports address, data separate
// - page mode: data exchanged on high port
// - burst: low A4-A11/data, high A12-A19
// - control zero: write strobe or read/write
// - control one: read, enable clock, data strobe
// - control one accepts program-fetch as read
// - control inputs routed to logic arrays
// - control two: fetch select or generic input
// - flash moves to data space during update
// - reset initialises ports, synchronisers, latched address, flash space
// - reset aborts flash program or erase
`timescale 1ns/1ps
module mcu_bus_front_end (
	input  wire logic                 CORE_CLK,             // core clock, 40 MHz
	input  wire logic                 NRST,                 // async reset, low
	input  wire mcu_fe_pkg::bus_cfg_s CFG,                  // static bus style
	input  wire logic [7:0]           LOW_ADDR_DATA_PORT_I,  // low port level
	output logic      [7:0]           LOW_ADDR_DATA_PORT_O,  // low port drive
	output logic      [7:0]           LOW_ADDR_DATA_PORT_OE, // low port enable
	input  wire logic [7:0]           HIGH_ADDR_DATA_PORT_I, // high port level
	output logic      [7:0]           HIGH_ADDR_DATA_PORT_O, // high port drive
	output logic      [7:0]           HIGH_ADDR_DATA_PORT_OE,// high port enable
	input  wire logic [7:0]           SEP_DATA_PORT_I,      // separate data level
	output logic      [7:0]           SEP_DATA_PORT_O,      // separate data drive
	output logic      [7:0]           SEP_DATA_PORT_OE,     // separate data enable
	input  wire logic                 CONTROL_IN_ZERO,      // write / read-write
	input  wire logic                 CONTROL_IN_ONE,       // read / e / data strobe / fetch
	input  wire logic                 CONTROL_IN_TWO,       // fetch select / generic
	input  wire logic                 ADDR_STROBE_ALT,      // address strobe pin
	input  wire logic                 UNIT_SEL,             // a unit decoded
	input  wire logic [7:0]           READ_DATA,            // data from units
	input  wire logic                 IN_APPLICATION_UPDATE,// flash to data space
	output logic      [19:0]          LATCHED_ADDR,         // held bus address
	output logic                      ADDR_VALID,           // address held
	output logic      [15:0]          LOGIC_ADDR,           // live port address
	output mcu_fe_pkg::bus_ctrl_s     LOGIC_CTRL,           // decoded controls
	output logic      [2:0]           LOGIC_CTL_RAW,        // synced control pins
	output logic                      READ_ACTIVE,          // read in progress
	output logic                      WRITE_PULSE,          // write done, 1 cycle
	output logic      [7:0]           WRITE_DATA,           // data of last write
	output logic                      PROG_FETCH,           // program space fetch
	output logic                      FLASH_DATA_SPACE,     // flash in data space
	output logic                      FLASH_ABORT           // abort flash cycle
);

	// ----------------------------------------
	// pin synchronisation
	// ----------------------------------------
	logic [mcu_fe_pkg::PIN_W-1:0] pins_raw;
	logic [mcu_fe_pkg::PIN_W-1:0] pins_s;
	logic [7:0]                   lo_s;
	logic [7:0]                   hi_s;
	logic [7:0]                   sd_s;
	logic [2:0]                   c_s;
	logic                         strb_s;

	assign pins_raw = {ADDR_STROBE_ALT, CONTROL_IN_TWO, CONTROL_IN_ONE, CONTROL_IN_ZERO,
		SEP_DATA_PORT_I, HIGH_ADDR_DATA_PORT_I, LOW_ADDR_DATA_PORT_I};

	pin_sync #(
		.WIDTH (mcu_fe_pkg::PIN_W)
	) u_sync (
		.clk   (CORE_CLK),
		.rst_n (NRST),
		.din   (pins_raw),
		.dout  (pins_s)
	);

	assign lo_s   = pins_s[mcu_fe_pkg::LO_LSB +: 8];
	assign hi_s   = pins_s[mcu_fe_pkg::HI_LSB +: 8];
	assign sd_s   = pins_s[mcu_fe_pkg::SD_LSB +: 8];
	assign c_s    = pins_s[mcu_fe_pkg::CTL_LSB +: 3];
	assign strb_s = pins_s[mcu_fe_pkg::STRB_BIT];

	// ----------------------------------------
	// control decode
	// ----------------------------------------
	mcu_fe_pkg::bus_ctrl_s ctrl;

	ctl_decode u_dec (
		.c0   (c_s[0]),
		.c1   (c_s[1]),
		.c2   (c_s[2]),
		.cfg  (CFG),
		.ctrl (ctrl)
	);

	assign LOGIC_CTRL    = ctrl;
	assign LOGIC_CTL_RAW = c_s;
	assign READ_ACTIVE = ctrl.read;
	assign PROG_FETCH  = ctrl.prog_fetch & ~FLASH_DATA_SPACE;

	// ----------------------------------------
	// address and data steering per bus style
	// ----------------------------------------
	logic [19:0] addr_live;
	logic [7:0]  data_live;

	always_comb
	begin
		case (CFG.style)
			mcu_fe_pkg::STYLE_BURST:
				addr_live = {hi_s, lo_s, 4'h0};
			default:
				addr_live = {4'h0, hi_s, lo_s};
		endcase
		case (CFG.style)
			mcu_fe_pkg::STYLE_NONMUX:
				data_live = sd_s;
			mcu_fe_pkg::STYLE_PAGE:
				data_live = hi_s;
			default:
				data_live = lo_s;
		endcase
	end

	assign LOGIC_ADDR = {hi_s, lo_s};

	// ----------------------------------------
	// address strobe and bus cycle tracking
	// ----------------------------------------
	logic        strb_act;
	logic        strb_act_q;
	logic        strb_armed_q;
	logic        capture;
	logic        acc_seen_q;
	logic [19:0] addr_q;
	mcu_fe_pkg::cyc_e state_q;

	// alternate strobe: low phase, latch at rising edge
	assign strb_act = CFG.strobe_alt ? ~strb_s : strb_s;
	assign capture  = strb_act_q & ~strb_act & strb_armed_q;

	// armed only once strobe seen idle, no false edge out of reset
	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			strb_act_q   <= 1'b0;
			strb_armed_q <= 1'b0;
		end
		else
		begin
			strb_act_q <= strb_act;
			if (!strb_act)
				strb_armed_q <= 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
			addr_q <= '0;
		else if (capture)
			addr_q <= addr_live;
	end

	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
			state_q <= mcu_fe_pkg::CYC_IDLE;
		else
		begin
			case (state_q)
				mcu_fe_pkg::CYC_IDLE:
					if (strb_act)
						state_q <= mcu_fe_pkg::CYC_ADDR;
				mcu_fe_pkg::CYC_ADDR:
					if (capture)
						state_q <= mcu_fe_pkg::CYC_HOLD;
				mcu_fe_pkg::CYC_HOLD:
					if (strb_act)
						state_q <= mcu_fe_pkg::CYC_ADDR;
					else if (acc_seen_q && !(ctrl.read || ctrl.write))
						state_q <= mcu_fe_pkg::CYC_IDLE;
				default:
					state_q <= mcu_fe_pkg::CYC_IDLE;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
			acc_seen_q <= 1'b0;
		else if (state_q != mcu_fe_pkg::CYC_HOLD)
			acc_seen_q <= 1'b0;
		else if (ctrl.read || ctrl.write)
			acc_seen_q <= 1'b1;
	end

	assign LATCHED_ADDR = addr_q;
	assign ADDR_VALID   = (state_q == mcu_fe_pkg::CYC_HOLD);

	// ----------------------------------------
	// read drive
	// ----------------------------------------
	logic [7:0] dout_q;
	logic       lo_en_q;
	logic       hi_en_q;
	logic       sd_en_q;
	logic       drive;

	assign drive = ctrl.read & UNIT_SEL;

	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			lo_en_q <= 1'b0;
			hi_en_q <= 1'b0;
			sd_en_q <= 1'b0;
			dout_q  <= '0;
		end
		else
		begin
			lo_en_q <= drive && (CFG.style == mcu_fe_pkg::STYLE_MUX ||
				CFG.style == mcu_fe_pkg::STYLE_BURST);
			hi_en_q <= drive && (CFG.style == mcu_fe_pkg::STYLE_PAGE);
			sd_en_q <= drive && (CFG.style == mcu_fe_pkg::STYLE_NONMUX);
			dout_q  <= READ_DATA;
		end
	end

	assign LOW_ADDR_DATA_PORT_O   = dout_q;
	assign HIGH_ADDR_DATA_PORT_O  = dout_q;
	assign SEP_DATA_PORT_O        = dout_q;
	assign LOW_ADDR_DATA_PORT_OE  = lo_en_q ? mcu_fe_pkg::OE_ON : mcu_fe_pkg::OE_RST;
	assign HIGH_ADDR_DATA_PORT_OE = hi_en_q ? mcu_fe_pkg::OE_ON : mcu_fe_pkg::OE_RST;
	assign SEP_DATA_PORT_OE       = sd_en_q ? mcu_fe_pkg::OE_ON : mcu_fe_pkg::OE_RST;

	// ----------------------------------------
	// write capture
	// ----------------------------------------
	logic       wr_q;
	logic       wr_pulse_q;
	logic [7:0] wdata_q;

	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			wr_q       <= 1'b0;
			wr_pulse_q <= 1'b0;
		end
		else
		begin
			wr_q       <= ctrl.write;
			wr_pulse_q <= wr_q & ~ctrl.write;
		end
	end

	// data sampled while strobe active, last value kept
	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
			wdata_q <= '0;
		else if (ctrl.write)
			wdata_q <= data_live;
	end

	assign WRITE_PULSE = wr_pulse_q;
	assign WRITE_DATA  = wdata_q;

	// ----------------------------------------
	// flash space and reset abort
	// ----------------------------------------
	logic upd_q;
	logic abort_q;

	// space swaps only between bus cycles
	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
			upd_q <= 1'b0;
		else if (state_q == mcu_fe_pkg::CYC_IDLE)
			upd_q <= IN_APPLICATION_UPDATE;
	end

	// held high through reset, cleared at the first edge after
	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
			abort_q <= mcu_fe_pkg::ABORT_RST;
		else
			abort_q <= 1'b0;
	end

	assign FLASH_DATA_SPACE = upd_q;
	assign FLASH_ABORT      = abort_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!NRST);

	property p_addr_capture;
		capture |=> LATCHED_ADDR == $past(addr_live) && ADDR_VALID;
	endproperty
	a_addr_capture: assert property (p_addr_capture) else $error("address not latched");

	property p_addr_hold;
		ADDR_VALID && !capture |=> $stable(LATCHED_ADDR);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("held address changed");

	property p_alt_rise;
		CFG.strobe_alt && $rose(strb_s) && $stable(CFG) |-> capture;
	endproperty
	a_alt_rise: assert property (p_alt_rise) else $error("rising strobe missed");

	property p_drive_cause;
		(LOW_ADDR_DATA_PORT_OE != 8'h00 || HIGH_ADDR_DATA_PORT_OE != 8'h00 || SEP_DATA_PORT_OE != 8'h00)
			|-> $past(ctrl.read && UNIT_SEL);
	endproperty
	a_drive_cause: assert property (p_drive_cause) else $error("drive without selected read");

	property p_page_port;
		CFG.style == mcu_fe_pkg::STYLE_PAGE && drive ##1 $stable(CFG)
			|-> HIGH_ADDR_DATA_PORT_OE == 8'hFF && LOW_ADDR_DATA_PORT_OE == 8'h00;
	endproperty
	a_page_port: assert property (p_page_port) else $error("page data not on high port");

	property p_burst_map;
		CFG.style == mcu_fe_pkg::STYLE_BURST && capture
			|=> LATCHED_ADDR[3:0] == 4'h0 && LATCHED_ADDR[19:12] == $past(hi_s);
	endproperty
	a_burst_map: assert property (p_burst_map) else $error("burst address misplaced");

	property p_write_pulse;
		WRITE_PULSE |-> $past(ctrl.write, 2) && !$past(ctrl.write) ##1 !WRITE_PULSE;
	endproperty
	a_write_pulse: assert property (p_write_pulse) else $error("write pulse misplaced");

	property p_rw_qual;
		CFG.ctl0_rw && CFG.ctl1 == mcu_fe_pkg::C1_ECLK && !c_s[1] |-> !ctrl.write;
	endproperty
	a_rw_qual: assert property (p_rw_qual) else $error("write without enable clock");

	property p_abort_once;
		!FLASH_ABORT |=> !FLASH_ABORT;
	endproperty
	a_abort_once: assert property (p_abort_once) else $error("abort outside reset");

	property p_upd_fetch;
		FLASH_DATA_SPACE |-> !PROG_FETCH;
	endproperty
	a_upd_fetch: assert property (p_upd_fetch) else $error("fetch while flash in data space");

endmodule

// ### bench/mcu_host_model.sv
// host microcontroller model on the parallel address/data bus
`timescale 1ns/1ps
module mcu_host_model (
	input  wire logic                 clk,    // core clock
	input  wire mcu_fe_pkg::bus_cfg_s cfg,    // bus style
	input  wire logic [7:0]           lo_o,   // device low drive
	input  wire logic [7:0]           lo_oe,  // device low enable
	input  wire logic [7:0]           hi_o,   // device high drive
	input  wire logic [7:0]           hi_oe,  // device high enable
	input  wire logic [7:0]           sd_o,   // device data drive
	input  wire logic [7:0]           sd_oe,  // device data enable
	output logic      [7:0]           lo_pin, // low port level
	output logic      [7:0]           hi_pin, // high port level
	output logic      [7:0]           sd_pin, // data port level
	output logic                      c0,     // control zero pin
	output logic                      c1,     // control one pin
	output logic                      c2,     // control two pin
	output logic                      strobe  // address strobe pin
);
	logic [7:0] lo_h = 8'h00;
	logic [7:0] hi_h = 8'h00;
	logic [7:0] sd_h = 8'h00;
	logic       c1_hi;

	assign c1_hi = (cfg.ctl1 == mcu_fe_pkg::C1_ECLK);
	assign lo_pin = (lo_oe & lo_o) | (~lo_oe & lo_h);
	assign hi_pin = (hi_oe & hi_o) | (~hi_oe & hi_h);
	assign sd_pin = (sd_oe & sd_o) | (~sd_oe & sd_h);

	initial
	begin
		c0 = 1'b1;
		c1 = 1'b1;
		c2 = 1'b1;
		strobe = 1'b0;
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic idle();
		c0 = 1'b1;
		c1 = ~c1_hi;
		strobe = cfg.strobe_alt;
	endtask

	// released lines show the inverse of the last value
	task automatic put_data(input logic [7:0] d, input logic rel);
		case (cfg.style)
			mcu_fe_pkg::STYLE_NONMUX: sd_h = rel ? ~sd_h : d;
			mcu_fe_pkg::STYLE_PAGE:   hi_h = rel ? ~hi_h : d;
			default:                  lo_h = rel ? ~lo_h : d;
		endcase
	endtask

	task automatic addr_phase(input logic [19:0] a);
		if (cfg.style == mcu_fe_pkg::STYLE_BURST)
		begin
			lo_h = a[11:4];
			hi_h = a[19:12];
		end
		else
		begin
			lo_h = a[7:0];
			hi_h = a[15:8];
		end
		strobe = ~cfg.strobe_alt;
		step(6);
		strobe = cfg.strobe_alt;
		step(6);
	endtask

	task automatic read_cyc(output logic [7:0] d, output logic [2:0] drv);
		put_data(8'h00, 1'b1);
		c0 = 1'b1;
		c1 = c1_hi;
		step(8);
		case (cfg.style)
			mcu_fe_pkg::STYLE_NONMUX: d = sd_pin;
			mcu_fe_pkg::STYLE_PAGE:   d = hi_pin;
			default:                  d = lo_pin;
		endcase
		drv = {sd_oe === 8'hFF, hi_oe === 8'hFF, lo_oe === 8'hFF};
		idle();
		step(6);
	endtask

	task automatic write_cyc(input logic [7:0] d);
		put_data(d, 1'b0);
		c0 = 1'b0;
		c1 = cfg.ctl0_rw ? c1_hi : ~c1_hi;
		step(6);
		idle();
		step(6);
		put_data(8'h00, 1'b1);
	endtask
endmodule

// ### bench/mcu_bus_interface_front_end_tb.sv
// self-checking bench of the mcu bus front end
`timescale 1ns/1ps
module mcu_bus_interface_front_end_tb;
	logic                  clk = 1'b0;
	logic                  nrst = 1'b0;
	mcu_fe_pkg::bus_cfg_s  cfg = '0;
	logic                  usel = 1'b0;
	logic                  upd = 1'b0;
	logic [7:0]            rdata = 8'h00;
	logic [7:0]            lo_o, lo_oe, hi_o, hi_oe, sd_o, sd_oe, lo_pin, hi_pin, sd_pin, wdata, d;
	logic                  c0, c1, c2, stb, avalid, ract, wpulse, pfetch, fds, fabort;
	logic [19:0]           laddr;
	logic [15:0]           paddr;
	logic [2:0]            craw, drv;
	mcu_fe_pkg::bus_ctrl_s pctrl;
	int                    num_errors = 0;
	int                    n_compared = 0;
	int                    cycles = 0;
	int                    n_pulse = 0;

	always #12.5 clk = ~clk;

	mcu_bus_front_end dut (.CORE_CLK(clk), .NRST(nrst), .CFG(cfg), .LOW_ADDR_DATA_PORT_I(lo_pin),
		.LOW_ADDR_DATA_PORT_O(lo_o), .LOW_ADDR_DATA_PORT_OE(lo_oe), .HIGH_ADDR_DATA_PORT_I(hi_pin),
		.HIGH_ADDR_DATA_PORT_O(hi_o), .HIGH_ADDR_DATA_PORT_OE(hi_oe), .SEP_DATA_PORT_I(sd_pin),
		.SEP_DATA_PORT_O(sd_o), .SEP_DATA_PORT_OE(sd_oe), .CONTROL_IN_ZERO(c0), .CONTROL_IN_ONE(c1),
		.CONTROL_IN_TWO(c2), .ADDR_STROBE_ALT(stb), .UNIT_SEL(usel), .READ_DATA(rdata),
		.IN_APPLICATION_UPDATE(upd), .LATCHED_ADDR(laddr), .ADDR_VALID(avalid), .LOGIC_ADDR(paddr),
		.LOGIC_CTRL(pctrl), .LOGIC_CTL_RAW(craw), .READ_ACTIVE(ract), .WRITE_PULSE(wpulse),
		.WRITE_DATA(wdata), .PROG_FETCH(pfetch), .FLASH_DATA_SPACE(fds), .FLASH_ABORT(fabort));

	mcu_host_model host (.clk(clk), .cfg(cfg), .lo_o(lo_o), .lo_oe(lo_oe), .hi_o(hi_o), .hi_oe(hi_oe),
		.sd_o(sd_o), .sd_oe(sd_oe), .lo_pin(lo_pin), .hi_pin(hi_pin), .sd_pin(sd_pin), .c0(c0),
		.c1(c1), .c2(c2), .strobe(stb));

	task automatic report_and_stop();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// cycle ceiling and write pulse count
	always @(posedge clk)
	begin
		cycles++;
		if (wpulse === 1'b1)
			n_pulse++;
		if (cycles == 20000)
		begin
			num_errors++;
			report_and_stop();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic t_reset();
		host.idle();
		tick(5);
		chk("abort in reset", 1, fabort);
		chk("low enable in reset", 0, lo_oe);
		chk("latched in reset", 0, laddr);
		nrst = 1'b1;
		tick(2);
		chk("abort after reset", 0, fabort);
	endtask

	task automatic t_write(input logic [7:0] w);
		int p;
		p = n_pulse;
		host.write_cyc(w);
		chk("write pulses", 1, n_pulse - p);
		chk("write data", w, wdata);
	endtask

	task automatic t_style(input int s);
		logic [19:0] a;
		logic [19:0] ea;
		a = 20'h9B3C5 + 20'(s) * 20'h01111;
		ea = (s == 3) ? {a[19:4], 4'h0} : {4'h0, a[15:0]};
		cfg.style = mcu_fe_pkg::bus_style_e'(s);
		host.idle();
		host.addr_phase(a);
		chk("live address", (s == 3) ? a[19:4] : a[15:0], paddr);
		chk("latched address", ea, laddr);
		chk("address valid", 1, avalid);
		rdata = 8'h5A + 8'(s);
		usel = 1'b1;
		host.read_cyc(d, drv);
		chk("read data", rdata, d);
		chk("driving port", (s == 1) ? 3'b100 : (s == 2) ? 3'b010 : 3'b001, drv);
		chk("address held", ea, laddr);
		usel = 1'b0;
		host.read_cyc(d, drv);
		chk("no unit no drive", 0, drv);
		t_write(8'h96 ^ 8'(s));
	endtask

	task automatic t_ctl1();
		cfg.style = mcu_fe_pkg::STYLE_MUX;
		for (int k = 0; k < 8; k++)
		begin
			cfg.ctl0_rw = k[2];
			cfg.ctl1 = mcu_fe_pkg::ctl1_mode_e'(k[1:0]);
			host.idle();
			tick(6);
			chk("idle no read", 0, ract);
			chk("raw controls", {2'b11, k[1:0] != 1}, {craw[0], craw[2], craw[1]});
			host.addr_phase(20'h04D2E + 20'(k));
			rdata = 8'hC3 ^ 8'(k);
			usel = 1'b1;
			host.read_cyc(d, drv);
			chk("mode read data", rdata, d);
			t_write(8'h3C + 8'(k));
		end
	endtask

	task automatic t_alt();
		cfg.style = mcu_fe_pkg::STYLE_NONMUX;
		cfg.strobe_alt = 1'b1;
		host.idle();
		tick(6);
		host.addr_phase(20'h01357);
		chk("rising strobe capture", 20'h01357, laddr);
		host.addr_phase(20'h0E8A4);
		chk("back to back capture", 20'h0E8A4, laddr);
	endtask

	task automatic t_fetch();
		usel = 1'b0;
		cfg.ctl2_fetch = 1'b1;
		host.c2 = 1'b0;
		tick(6);
		chk("fetch select", 1, pfetch);
		chk("decoded fetch", 1, pctrl.prog_fetch);
		host.c2 = 1'b1;
		tick(6);
		upd = 1'b1;
		tick(3);
		chk("flash in data space", 1, fds);
		host.c2 = 1'b0;
		tick(6);
		chk("fetch while updating", 0, pfetch);
		host.c2 = 1'b1;
		cfg.ctl2_fetch = 1'b0;
		tick(6);
		chk("generic high", 1, pctrl.generic_in);
		host.c2 = 1'b0;
		tick(6);
		chk("generic low", 0, pctrl.generic_in);
		chk("no fetch as generic", 0, pfetch);
		host.c2 = 1'b1;
		tick(6);
	endtask

	task automatic t_midreset();
		nrst = 1'b0;
		tick(1);
		chk("abort on reset", 1, fabort);
		chk("data space reset", 0, fds);
		chk("latched reset", 0, laddr);
		upd = 1'b0;
		nrst = 1'b1;
		tick(2);
		chk("abort released", 0, fabort);
	endtask

	initial
	begin
		t_reset();
		for (int s = 0; s < 4; s++)
			t_style(s);
		t_ctl1();
		t_alt();
		t_fetch();
		t_midreset();
		report_and_stop();
	end
endmodule
